/* logic/bor_seq_regs.vh */
// Register map, field layout and timing constants of the reset sequencer
`ifndef BOR_SEQ_REGS_VH
`define BOR_SEQ_REGS_VH

// Register indices; byte address is four times the index
`define IDX_CORE_STATUS 8'h03
`define IDX_POWER_CAUSE 8'h04
`define IDX_CONFIG 8'h05

// core_status_flags fields
`define STAT_TIMEOUT_BIT 4
`define STAT_POWERDOWN_BIT 3
`define STAT_RESET 8'h18

// power_reset_cause fields
`define CAUSE_BROWNOUT_BIT 0
`define CAUSE_SUPPLY_BIT 1
`define CAUSE_RESET 8'h00

// Configuration fields
`define CFG_BOR_EN_LSB 0
`define CFG_BOR_EN_MSB 1
`define CFG_TRIP_BIT 2
`define CFG_POWERUP_DELAY_TIMER_DIS_BIT 3
`define CFG_OSC_LSB 4
`define CFG_OSC_MSB 5
`define CFG_RESET 8'h03

// Oscillator mode codes
`define OSC_INTERNAL 2'h0
`define OSC_EXTERNAL 2'h1
`define OSC_CRYSTAL 2'h2
`define OSC_RC 2'h3

`define TRIP_LOWEST 1'b0

// Timing
`define CLK_PERIOD_NS 25
`define POWERUP_DELAY_TIMER_TIME_MS 64
`define WDT_OSC_HZ 31000
`define POWERUP_DELAY_TIMER_TICKS ((`POWERUP_DELAY_TIMER_TIME_MS * `WDT_OSC_HZ) / 1000)
`define OST_TICKS 1024
`define BOR_MIN_NS 100
`define BOR_MIN_CYC ((`BOR_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* logic/reset_sequencer.v */
// Brown-out, power-up delay and start-up sequencing with reset cause flags
`timescale 1ns/100ps
`include "bor_seq_regs.vh"
module reset_sequencer (
   input wire aclk,
   input wire aresetn,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire supply_reset_pin,
   input wire vdd_below_trip,
   input wire external_reset_pin_n,
   input wire wdt_osc_clk,
   input wire sys_osc_clk,
   input wire flash_erase,
   input wire sleep_req,
   input wire int_wake_evt,
   input wire wdt_wake_evt,
   input wire wdt_reset_evt,
   output reg chip_reset_ff,
   output reg brownout_detect_en_ff,
   output reg brownout_trip_select_ff,
   output reg wdt_hold_ff,
   output reg sleeping_ff,
   output reg wake_resume_ff
);
   localparam [2:0] S_POR = 3'h0;
   localparam [2:0] S_BOR = 3'h1;
   localparam [2:0] S_POWERUP_DELAY_TIMER = 3'h2;
   localparam [2:0] S_OST = 3'h3;
   localparam [2:0] S_RUN = 3'h4;
   localparam [2:0] S_SLEEP = 3'h5;
   localparam [2:0] S_WAKE_OST = 3'h6;
   localparam [31:0] BOR_MIN_FULL = `BOR_MIN_CYC;
   localparam [7:0] BOR_MIN = BOR_MIN_FULL[7:0];

   // Pins from outside the clock domain: two flops each
   reg [4:0] pin_s1_ff;
   reg [4:0] pin_s2_ff;
   reg wdt_osc_prev_ff;
   reg sys_osc_prev_ff;
   wire por_s = pin_s2_ff[0];
   wire vlow_s = pin_s2_ff[1];
   wire ext_n_s = pin_s2_ff[2];
   wire wdt_tick = pin_s2_ff[3] & ~wdt_osc_prev_ff;
   wire sys_tick = pin_s2_ff[4] & ~sys_osc_prev_ff;

   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_ff <= 5'h01;
         pin_s2_ff <= 5'h01;
         wdt_osc_prev_ff <= 1'b0;
         sys_osc_prev_ff <= 1'b0;
      end else begin
         pin_s1_ff <= {sys_osc_clk, wdt_osc_clk, external_reset_pin_n,
                       vdd_below_trip, supply_reset_pin};
         pin_s2_ff <= pin_s1_ff;
         wdt_osc_prev_ff <= pin_s2_ff[3];
         sys_osc_prev_ff <= pin_s2_ff[4];
      end
   end

   reg [7:0] status_ff;
   reg [7:0] cause_ff;
   reg [7:0] config_ff;
   wire [1:0] bor_en = config_ff[`CFG_BOR_EN_MSB:`CFG_BOR_EN_LSB];
   wire [1:0] osc_mode = config_ff[`CFG_OSC_MSB:`CFG_OSC_LSB];
   wire powerup_delay_timer_on = ~config_ff[`CFG_POWERUP_DELAY_TIMER_DIS_BIT];
   wire crystal = (osc_mode == `OSC_CRYSTAL);

   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [7:0] bor_cnt_ff;
   reg bor_trip_ff;

   // Erase overrides the enable field and the threshold
   wire bor_active = flash_erase | (bor_en == 2'h3) |
      ((bor_en == 2'h2) & (state_ff != S_SLEEP));

   // Trip only after the supply has stayed low past the minimum time
   always @(posedge aclk) begin
      if (!aresetn) begin
         bor_cnt_ff <= 8'h00;
         bor_trip_ff <= 1'b0;
      end else if (bor_active && vlow_s) begin
         if (bor_cnt_ff != BOR_MIN) begin
            bor_cnt_ff <= bor_cnt_ff + 8'h01;
         end
         bor_trip_ff <= (bor_cnt_ff == BOR_MIN);
      end else begin
         bor_cnt_ff <= 8'h00;
         bor_trip_ff <= 1'b0;
      end
   end

   wire powerup_delay_timer_done;
   wire ost_done;
   // Timer reloads whenever the sequence leaves the delay stage
   tick_counter #(.WIDTH(11), .LAST(`POWERUP_DELAY_TIMER_TICKS)) u_powerup_delay_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(state_ff != S_POWERUP_DELAY_TIMER),
      .tick(wdt_tick),
      .done_ff(powerup_delay_timer_done)
   );
   tick_counter #(.WIDTH(11), .LAST(`OST_TICKS)) u_ost (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear((state_ff != S_OST) && (state_ff != S_WAKE_OST)),
      .tick(sys_tick),
      .done_ff(ost_done)
   );

   wire wake_evt = int_wake_evt | wdt_wake_evt;
   // Stage after supply or brown-out release
   wire [2:0] after_rst = powerup_delay_timer_on ? S_POWERUP_DELAY_TIMER : (crystal ? S_OST : S_RUN);

   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         S_POR: begin
            if (!por_s) begin
               nxt_state = after_rst;
            end
         end
         S_BOR: begin
            if (!vlow_s) begin
               nxt_state = after_rst;
            end
         end
         S_POWERUP_DELAY_TIMER: begin
            if (powerup_delay_timer_done) begin
               nxt_state = crystal ? S_OST : S_RUN;
            end
         end
         S_OST: begin
            if (ost_done) begin
               nxt_state = S_RUN;
            end
         end
         S_RUN: begin
            if (sleep_req) begin
               nxt_state = S_SLEEP;
            end
         end
         S_SLEEP: begin
            if (wake_evt) begin
               nxt_state = crystal ? S_WAKE_OST : S_RUN;
            end
         end
         S_WAKE_OST: begin
            if (ost_done) begin
               nxt_state = S_RUN;
            end
         end
         default: begin
            nxt_state = S_POR;
         end
      endcase
      if (bor_trip_ff && (state_ff != S_POR)) begin
         nxt_state = S_BOR;
      end
      if (por_s) begin
         nxt_state = S_POR;
      end
   end

   wire enter_bor = bor_trip_ff && (state_ff != S_POR) &&
      (state_ff != S_BOR) && !por_s;
   wire resume = (state_ff == S_SLEEP && wake_evt && !crystal) ||
      (state_ff == S_WAKE_OST && ost_done);
   wire core_up = (state_ff == S_RUN) || (state_ff == S_SLEEP) ||
      (state_ff == S_WAKE_OST);

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_ff <= S_POR;
         chip_reset_ff <= 1'b1;
         brownout_detect_en_ff <= 1'b1;
         brownout_trip_select_ff <= `TRIP_LOWEST;
         wdt_hold_ff <= 1'b0;
         sleeping_ff <= 1'b0;
         wake_resume_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         // Pin gates this output and, in sleep, clears the power-down flag; the time-outs run on
         chip_reset_ff <= ~core_up | ~ext_n_s | wdt_reset_evt |
            (nxt_state == S_POR) | (nxt_state == S_BOR);
         brownout_detect_en_ff <= bor_active;
         brownout_trip_select_ff <= flash_erase ? `TRIP_LOWEST :
            config_ff[`CFG_TRIP_BIT];
         wdt_hold_ff <= (nxt_state == S_OST) ||
            (nxt_state == S_WAKE_OST);
         sleeping_ff <= (nxt_state == S_SLEEP);
         // Wake keeps registers; core steps to the next instruction
         wake_resume_ff <= resume;
      end
   end

   // AXI4-Lite slave, one write and one read at a time
   reg aw_have_ff;
   reg w_have_ff;
   reg [7:0] waddr_ff;
   reg [7:0] wdata_ff;
   reg wstrb0_ff;
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire do_write = aw_have_ff & w_have_ff & ~s_axi_bvalid;
   wire nxt_aw_have = aw_have_ff ? ~do_write : aw_take;
   wire nxt_w_have = w_have_ff ? ~do_write : w_take;
   wire nxt_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire nxt_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
   wire [7:0] ar_word = s_axi_araddr[9:2];
   wire ar_ok = (s_axi_araddr[31:10] == 22'h000000) &&
      ((ar_word == `IDX_CORE_STATUS) || (ar_word == `IDX_POWER_CAUSE) ||
       (ar_word == `IDX_CONFIG));
   wire wr_ok = (waddr_ff == `IDX_CORE_STATUS) ||
      (waddr_ff == `IDX_POWER_CAUSE) || (waddr_ff == `IDX_CONFIG);
   wire wr_en = do_write & wstrb0_ff;
   reg [7:0] rd_mux;

   always @* begin
      case (ar_word)
         `IDX_CORE_STATUS: rd_mux = status_ff;
         `IDX_POWER_CAUSE: rd_mux = cause_ff;
         `IDX_CONFIG: rd_mux = config_ff;
         default: rd_mux = 8'h00;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         waddr_ff <= 8'h00;
         wdata_ff <= 8'h00;
         wstrb0_ff <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         aw_have_ff <= nxt_aw_have;
         w_have_ff <= nxt_w_have;
         if (aw_take) begin
            // Upper address bits are kept out of range by a nonzero word
            waddr_ff <= (s_axi_awaddr[31:10] == 22'h000000) ?
               s_axi_awaddr[9:2] : 8'hFF;
         end
         if (w_take) begin
            wdata_ff <= s_axi_wdata[7:0];
            wstrb0_ff <= s_axi_wstrb[0];
         end
         s_axi_awready <= ~nxt_aw_have & ~nxt_bvalid;
         s_axi_wready <= ~nxt_w_have & ~nxt_bvalid;
         s_axi_bvalid <= nxt_bvalid;
         if (do_write) begin
            s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
         s_axi_arready <= ~nxt_rvalid;
         s_axi_rvalid <= nxt_rvalid;
         if (ar_take) begin
            s_axi_rdata <= {24'h000000, ar_ok ? rd_mux : 8'h00};
            s_axi_rresp <= ar_ok ? `RESP_OKAY : `RESP_SLVERR;
         end
      end
   end

   // Flags: software write first, hardware events override it
   wire sw_stat = wr_en && (waddr_ff == `IDX_CORE_STATUS);
   wire sw_cause = wr_en && (waddr_ff == `IDX_POWER_CAUSE);
   wire ext_in_sleep = ~ext_n_s && (state_ff == S_SLEEP);

   always @(posedge aclk) begin
      if (!aresetn) begin
         status_ff <= `STAT_RESET;
         cause_ff <= `CAUSE_RESET;
         config_ff <= `CFG_RESET;
      end else begin
         if (wr_en && (waddr_ff == `IDX_CONFIG)) begin
            config_ff <= wdata_ff;
         end
         // Timeout and power-down bits are read-only to software
         if (sw_stat) begin
            status_ff <= {wdata_ff[7:5], status_ff[4:3], wdata_ff[2:0]};
         end
         if (sw_cause) begin
            cause_ff <= {6'h00, wdata_ff[1:0]};
         end
         if (por_s) begin
            status_ff[`STAT_TIMEOUT_BIT] <= 1'b1;
            status_ff[`STAT_POWERDOWN_BIT] <= 1'b1;
            // Brown-out bit left as it was: undefined after power-up
            cause_ff[`CAUSE_SUPPLY_BIT] <= 1'b0;
         end else if (enter_bor) begin
            status_ff[`STAT_TIMEOUT_BIT] <= 1'b1;
            status_ff[`STAT_POWERDOWN_BIT] <= 1'b1;
            // With the field at 00 a trip occurs only while flash_erase is high
            cause_ff[`CAUSE_BROWNOUT_BIT] <= 1'b0;
         end else if (state_ff == S_SLEEP && wdt_wake_evt) begin
            status_ff[`STAT_TIMEOUT_BIT] <= 1'b0;
            status_ff[`STAT_POWERDOWN_BIT] <= 1'b0;
         end else if (state_ff == S_SLEEP && int_wake_evt) begin
            status_ff[`STAT_TIMEOUT_BIT] <= 1'b1;
            status_ff[`STAT_POWERDOWN_BIT] <= 1'b0;
         end else if (wdt_reset_evt && core_up) begin
            status_ff[`STAT_TIMEOUT_BIT] <= 1'b0;
         end else if (ext_in_sleep) begin
            status_ff[`STAT_POWERDOWN_BIT] <= 1'b0;
         end
      end
   end
endmodule

/* logic/tick_counter.v */
// Synchronous tick counter with registered terminal count
`timescale 1ns/100ps
module tick_counter #(
   parameter WIDTH = 11,
   parameter LAST = 1024
) (
   input wire aclk,
   input wire aresetn,
   input wire clear,
   input wire tick,
   output reg done_ff
);
   localparam [31:0] LAST_FULL = LAST - 1;
   localparam [WIDTH-1:0] LAST_M1 = LAST_FULL[WIDTH-1:0];
   reg [WIDTH-1:0] count_ff;

   always @(posedge aclk) begin
      if (!aresetn || clear) begin
         count_ff <= {WIDTH{1'b0}};
         done_ff <= 1'b0;
      end else if (tick && !done_ff) begin
         count_ff <= count_ff + 1'b1;
         // Release lands one edge after the terminal tick
         if (count_ff == LAST_M1) begin
            done_ff <= 1'b1;
         end
      end
   end
endmodule

/* tb/reset_sequencer_sva.sv */
// Port-level assertions for the reset sequencer
`timescale 1ns/100ps
module reset_sequencer_sva (
   input logic aclk,
   input logic aresetn,
   input logic flash_erase,
   input logic supply_reset_pin,
   input logic vdd_below_trip,
   input logic external_reset_pin_n,
   input logic wdt_reset_evt,
   input logic chip_reset_ff,
   input logic brownout_detect_en_ff,
   input logic sleeping_ff,
   input logic brownout_trip_select_ff,
   input logic wake_resume_ff,
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic [1:0] s_axi_bresp,
   input logic [1:0] s_axi_rresp,
   input logic [31:0] s_axi_rdata
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_wr_resp;
      s_wr_take |=> !s_axi_awready ##1 s_axi_bvalid;
   endproperty
   property p_rd_resp;
      s_rd_take |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=>
         s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   property p_erase;
      flash_erase [*3] |-> brownout_detect_en_ff && !brownout_trip_select_ff;
   endproperty
   property p_supply;
      supply_reset_pin [*4] |=> chip_reset_ff;
   endproperty
   property p_pin;
      !external_reset_pin_n [*4] |=> chip_reset_ff;
   endproperty
   property p_brown;
      (vdd_below_trip && brownout_detect_en_ff) [*8] |-> ##[1:4] chip_reset_ff;
   endproperty
   property p_release;
      $fell(chip_reset_ff) |->
         $past(external_reset_pin_n, 3) && !$past(supply_reset_pin, 3);
   endproperty
   property p_wake;
      wake_resume_ff |-> !chip_reset_ff ##1 !wake_resume_ff;
   endproperty
   property p_wdt;
      wdt_reset_evt && !chip_reset_ff && !sleeping_ff |=> chip_reset_ff;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
   a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   a_erase: assert property (p_erase) else $error("erase not forced");
   a_supply: assert property (p_supply) else $error("no supply hold");
   a_pin: assert property (p_pin) else $error("pin not holding");
   a_brown: assert property (p_brown) else $error("no brown trip");
   a_release: assert property (p_release) else $error("early exit");
   a_wake: assert property (p_wake) else $error("bad resume");
   a_wdt: assert property (p_wdt) else $error("no wdt reset");
endmodule
bind reset_sequencer reset_sequencer_sva chk (.aclk, .aresetn,
   .flash_erase, .supply_reset_pin, .vdd_below_trip, .external_reset_pin_n,
   .wdt_reset_evt, .chip_reset_ff, .brownout_detect_en_ff, .sleeping_ff,
   .brownout_trip_select_ff, .wake_resume_ff, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_bresp, .s_axi_rresp, .s_axi_rdata);

/* tb/supply_partner.sv */
// Supply monitor, oscillators and reset pin facing the reset sequencer
`timescale 1ns/100ps
module supply_partner (
   input wire aclk,
   input wire por_on,
   input wire brown_on,
   input wire pin_low,
   output reg supply_reset_pin,
   output reg vdd_below_trip,
   output reg external_reset_pin_n,
   output reg wdt_osc_clk,
   output reg sys_osc_clk
);
   reg [1:0] div_ff = 2'h0;
   initial begin
      supply_reset_pin = 1'b1;
      vdd_below_trip = 1'b0;
      external_reset_pin_n = 1'b1;
      wdt_osc_clk = 1'b0;
      sys_osc_clk = 1'b0;
   end
   // Oscillators free-run at aclk/4, two aclk high and low, so counts end soon
   always @(posedge aclk) begin
      div_ff <= div_ff + 2'h1;
      wdt_osc_clk <= div_ff[1];
      sys_osc_clk <= ~div_ff[1];
      supply_reset_pin <= por_on;
      vdd_below_trip <= brown_on;
      external_reset_pin_n <= ~pin_low;
   end
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the reset sequencer
`timescale 1ns/100ps
`include "bor_seq_regs.vh"
module tb_top;
   localparam [7:0] A_ST = 8'(`IDX_CORE_STATUS * 4);
   localparam [7:0] A_CA = 8'(`IDX_POWER_CAUSE * 4);
   localparam [7:0] A_CF = 8'(`IDX_CONFIG * 4);
   localparam int T_POWERUP_DELAY_TIMER = `POWERUP_DELAY_TIMER_TICKS * 4;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic supply_reset_pin, vdd_below_trip, external_reset_pin_n;
   logic wdt_osc_clk, sys_osc_clk, flash_erase, sleep_req, int_wake_evt;
   logic wdt_wake_evt, wdt_reset_evt, chip_reset_ff, brownout_detect_en_ff;
   logic brownout_trip_select_ff, wdt_hold_ff, sleeping_ff, wake_resume_ff;
   logic por_on, brown_on, pin_low;
   int mismatches = 0;
   int num_checks = 0;
   int n;
   reset_sequencer uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_reset_pin,
      .vdd_below_trip, .external_reset_pin_n, .wdt_osc_clk, .sys_osc_clk,
      .flash_erase, .sleep_req, .int_wake_evt, .wdt_wake_evt,
      .wdt_reset_evt, .chip_reset_ff, .brownout_detect_en_ff,
      .brownout_trip_select_ff, .wdt_hold_ff, .sleeping_ff, .wake_resume_ff);
   supply_partner far_side (.aclk, .por_on, .brown_on, .pin_low,
      .supply_reset_pin, .vdd_below_trip, .external_reset_pin_n,
      .wdt_osc_clk, .sys_osc_clk);
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= {24'h000000, a};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e,
         input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= {24'h000000, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rdata, e);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
      s_axi_rready <= 1'b0;
   endtask
   task automatic wait_rel;
      n = 0;
      while (chip_reset_ff !== 1'b0 && n < 20000) begin
         @(posedge aclk);
         n++;
      end
   endtask
   // Window allows for synchroniser and oscillator phase
   task automatic near(input int t);
      chk(32'(n >= t - 8 && n <= t + 24), 32'h1);
   endtask
   task automatic brown;
      @(posedge aclk);
      brown_on <= 1'b1;
      repeat (20) @(posedge aclk);
      brown_on <= 1'b0;
   endtask
   // One-cycle strobe: 0 sleep request, 1 watchdog reset, 2 erase
   task automatic pulse(input int sel);
      @(posedge aclk);
      sleep_req <= (sel == 0);
      wdt_reset_evt <= (sel == 1);
      flash_erase <= (sel == 2);
      @(posedge aclk);
      {sleep_req, wdt_reset_evt, flash_erase} <= 3'h0;
      repeat (4) @(posedge aclk);
   endtask
   task automatic t_powerup;
      @(posedge aclk);
      por_on <= 1'b0;
      wait_rel;
      near(T_POWERUP_DELAY_TIMER);
      rchk(A_ST, 32'h18, `RESP_OKAY);
      rchk(A_CA, 32'h00, `RESP_OKAY);
      rchk(A_CF, 32'h03, `RESP_OKAY);
      rchk(8'h40, 32'h00, `RESP_SLVERR);
      $display("test powerup done");
   endtask
   task automatic t_brown;
      wr(A_CA, 8'h03);
      brown;
      repeat (500) @(posedge aclk);
      brown;
      wait_rel;
      near(T_POWERUP_DELAY_TIMER);
      rchk(A_CA, 32'h02, `RESP_OKAY);
      rchk(A_ST, 32'h18, `RESP_OKAY);
      $display("test brownout done");
   endtask
   task automatic t_modes;
      wr(A_CF, 8'h02);
      pulse(0);
      chk(brownout_detect_en_ff, 32'h0);
      @(posedge aclk);
      int_wake_evt <= 1'b1;
      @(posedge aclk);
      int_wake_evt <= 1'b0;
      n = 0;
      while (wake_resume_ff !== 1'b1 && n < 50) begin
         @(posedge aclk);
         n++;
      end
      chk(wake_resume_ff, 32'h1);
      repeat (3) @(posedge aclk);
      chk(brownout_detect_en_ff, 32'h1);
      rchk(A_ST, 32'h10, `RESP_OKAY);
      pulse(1);
      rchk(A_ST, 32'h00, `RESP_OKAY);
      wr(A_CF, 8'h07);
      // Trip output follows the stored config one edge after the write
      @(posedge aclk);
      chk(brownout_trip_select_ff, 32'h1);
      pulse(2);
      @(posedge aclk);
      flash_erase <= 1'b1;
      wr(A_CF, 8'h00);
      chk(brownout_detect_en_ff, 32'h1);
      @(posedge aclk);
      flash_erase <= 1'b0;
      repeat (4) @(posedge aclk);
      chk(brownout_detect_en_ff, 32'h0);
      $display("test modes done");
   endtask
   task automatic t_osc;
      wr(A_CF, 8'h1B);
      brown;
      wait_rel;
      chk(32'(n < 12), 32'h1);
      wr(A_CF, 8'h2B);
      brown;
      repeat (100) @(posedge aclk);
      chk(wdt_hold_ff, 32'h1);
      wait_rel;
      n = n + 100;
      near(`OST_TICKS * 4);
      chk(wdt_hold_ff, 32'h0);
      $display("test oscillator done");
   endtask
   task automatic t_wake;
      pulse(0);
      @(posedge aclk);
      pin_low <= 1'b1;
      repeat (8) @(posedge aclk);
      pin_low <= 1'b0;
      repeat (4) @(posedge aclk);
      chk(sleeping_ff, 32'h1);
      rchk(A_ST, 32'h10, `RESP_OKAY);
      @(posedge aclk);
      wdt_wake_evt <= 1'b1;
      @(posedge aclk);
      wdt_wake_evt <= 1'b0;
      n = 0;
      while (wake_resume_ff !== 1'b1 && n < 5000) begin
         @(posedge aclk);
         n++;
      end
      near(`OST_TICKS * 4);
      rchk(A_ST, 32'h00, `RESP_OKAY);
      // Pin held low past the whole time-out, then released
      @(posedge aclk);
      pin_low <= 1'b1;
      brown;
      repeat (4300) @(posedge aclk);
      chk(chip_reset_ff, 32'h1);
      chk(wdt_hold_ff, 32'h0);
      pin_low <= 1'b0;
      wait_rel;
      chk(32'(n < 8), 32'h1);
      $display("test wake and pin done");
   endtask
   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'hF;
      {flash_erase, sleep_req, int_wake_evt} = 3'h0;
      {wdt_wake_evt, wdt_reset_evt} = 2'h0;
      {por_on, brown_on, pin_low} = 3'h4;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_powerup;
      t_brown;
      t_modes;
      t_osc;
      t_wake;
      end_sim;
   end
   // Whole run needs about 31000 cycles
   initial begin
      #1500000;
      mismatches++;
      end_sim;
   end
endmodule
